// >>> src/flash_status_config_regs.sv
/*
 * Fifth and sixth status registers of a serial flash, reached over SPI
 * command frames, with the battery test sequencer and suspend flags.
 * Assumes SPI mode 0, a host clock that only runs inside frames, and
 * suspend/resume and battery comparator signals from the flash core.
 */
`timescale 1ns/1ps
module flash_status_config_regs
    import flash_status_pkg::*;
#(
    parameter int SHORT_LOAD_CYCLES = LOAD_SHORT_CYCLES,
    parameter int LONG_LOAD_CYCLES = LOAD_LONG_CYCLES
) (
    // system clock
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    // spi link
    input wire logic spi_clk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    // flash core events
    input wire logic erase_suspend_evt,
    input wire logic erase_clear_evt,
    input wire logic program_suspend_evt,
    input wire logic program_clear_evt,
    // battery analog front end
    input wire logic battery_below_async,
    output logic battery_load_en,
    output battery_cfg_t battery_cfg,
    // core control
    output xip_req_t xip_req,
    output logic xip_req_valid,
    output logic abort_pulse,
    output logic regs_locked_flag
);

    typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_BODY} frame_state_t;
    typedef enum logic {BAT_IDLE, BAT_LOAD} bat_state_t;

    function automatic logic [3:0] dummy_clocks(input logic [2:0] code);
        dummy_clocks = DUMMY_BASE_CLOCKS + {code, 1'b0};
    endfunction : dummy_clocks

    // =====================================================================
    // link domain: receive
    logic [2:0] bit_cnt_reg;
    logic [6:0] rx_shift_reg;
    logic [7:0] rx_byte_reg;
    logic rx_tgl_reg;

    // cs_n high ends the frame, so the link side never waits on an edge after it
    always_ff @(posedge spi_clk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            bit_cnt_reg <= 3'h0;
            rx_shift_reg <= 7'h00;
            rx_byte_reg <= 8'h00;
            rx_tgl_reg <= 1'b0;
        end else begin
            rx_shift_reg <= {rx_shift_reg[5:0], spi_mosi};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
                rx_byte_reg <= {rx_shift_reg, spi_mosi};
                rx_tgl_reg <= ~rx_tgl_reg;
            end
        end
    end

    // =====================================================================
    // link domain: transmit
    logic [7:0] reply_reg, tx_shift_reg;
    logic reply_tgl_reg, tx_oe_reg, rp_meta_reg, rp_sync_reg, rp_seen_reg;
    always_ff @(negedge spi_clk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            tx_shift_reg <= 8'h00;
            tx_oe_reg <= 1'b0;
            rp_meta_reg <= 1'b0;
            rp_sync_reg <= 1'b0;
            rp_seen_reg <= 1'b0;
        end else begin
            rp_meta_reg <= reply_tgl_reg;
            rp_sync_reg <= rp_meta_reg;
            tx_oe_reg <= 1'b1;
            if (bit_cnt_reg == 3'h0) begin
                // reply word is held still by the sys side once its toggle moved
                tx_shift_reg <= (rp_sync_reg != rp_seen_reg) ? reply_reg : 8'h00;
                rp_seen_reg <= rp_sync_reg;
            end else begin
                tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
            end
        end
    end

    assign spi_miso = tx_shift_reg[7];
    assign spi_miso_oe = tx_oe_reg;

    // =====================================================================
    // sys domain: crossings
    logic cs_meta_reg, cs_sync_reg, cs_prev_reg, rx_meta_reg, rx_sync_reg, rx_seen_reg, bat_meta_reg, bat_sync_reg;
    logic frame_start, frame_end, byte_evt;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cs_meta_reg <= 1'b1;
            cs_sync_reg <= 1'b1;
            cs_prev_reg <= 1'b1;
            rx_meta_reg <= 1'b0;
            rx_sync_reg <= 1'b0;
            rx_seen_reg <= 1'b0;
            bat_meta_reg <= 1'b0;
            bat_sync_reg <= 1'b0;
        end else if (ce) begin
            cs_meta_reg <= spi_cs_n;
            cs_sync_reg <= cs_meta_reg;
            cs_prev_reg <= cs_sync_reg;
            rx_meta_reg <= rx_tgl_reg;
            rx_sync_reg <= rx_meta_reg;
            rx_seen_reg <= frame_start ? 1'b0 : rx_sync_reg;
            bat_meta_reg <= battery_below_async;
            bat_sync_reg <= bat_meta_reg;
        end
    end

    assign frame_start = cs_prev_reg & ~cs_sync_reg;
    assign frame_end = ~cs_prev_reg & cs_sync_reg;
    assign byte_evt = (rx_sync_reg != rx_seen_reg) & ~cs_sync_reg & ~frame_start;

    // =====================================================================
    // sys domain: frame decode
    frame_state_t state_reg;
    logic [2:0] byte_idx_reg;
    logic [7:0] cmd_reg;
    logic cmd_evt, body_evt;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            byte_idx_reg <= 3'h0;
            cmd_reg <= 8'h00;
        end else if (ce) begin
            case (state_reg)
                ST_IDLE: begin
                    byte_idx_reg <= 3'h0;
                    if (frame_start) begin
                        state_reg <= ST_CMD;
                    end
                end
                ST_CMD: begin
                    if (frame_end) begin
                        state_reg <= ST_IDLE;
                    end else if (byte_evt) begin
                        cmd_reg <= rx_byte_reg;
                        byte_idx_reg <= 3'h1;
                        state_reg <= ST_BODY;
                    end
                end
                ST_BODY: begin
                    if (frame_end) begin
                        state_reg <= ST_IDLE;
                    end else if (byte_evt && byte_idx_reg != 3'h7) begin
                        byte_idx_reg <= byte_idx_reg + 3'h1;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    assign cmd_evt = byte_evt & (state_reg == ST_CMD);
    assign body_evt = byte_evt & (state_reg == ST_BODY);

    // =====================================================================
    // fifth register
    logic [2:0] dummy_cycle_count_reg;
    logic erase_paused_flag_reg, program_paused_flag_reg, abort_cmd_allow_reg, dword_align_select_reg;
    logic lock_key1_ok_reg, write5;
    logic [7:0] status_five_config;
    assign write5 = body_evt & (cmd_reg == CMD_WRITE_SR5) & (byte_idx_reg == 3'h1) & ~regs_locked_flag;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            regs_locked_flag <= 1'b0;
            lock_key1_ok_reg <= 1'b0;
        end else if (ce) begin
            if (cmd_evt) begin
                lock_key1_ok_reg <= 1'b0;
            end else if (body_evt && cmd_reg == CMD_LOCK && byte_idx_reg == 3'h1) begin
                lock_key1_ok_reg <= (rx_byte_reg == LOCK_KEY1);
            end else if (body_evt && cmd_reg == CMD_LOCK && byte_idx_reg == 3'h2) begin
                if (lock_key1_ok_reg && rx_byte_reg == LOCK_KEY2) begin
                    regs_locked_flag <= 1'b1;
                end
            end
        end
    end

    // sys_rst stands for a power cycle; nothing else reloads these bits
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dummy_cycle_count_reg <= DUMMY_RESET;
            abort_cmd_allow_reg <= 1'b0;
            dword_align_select_reg <= 1'b0;
        end else if (ce && write5) begin
            if (rx_byte_reg[SR5_DUMMY_LSB +: 3] <= DUMMY_CODE_MAX) begin
                dummy_cycle_count_reg <= rx_byte_reg[SR5_DUMMY_LSB +: 3];
            end
            abort_cmd_allow_reg <= rx_byte_reg[SR5_ABORT_BIT];
            dword_align_select_reg <= rx_byte_reg[SR5_ALIGN_BIT];
        end
    end

    // a suspend arriving with a clear keeps the flag set
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            erase_paused_flag_reg <= 1'b0;
            program_paused_flag_reg <= 1'b0;
        end else if (ce) begin
            if (erase_suspend_evt) begin
                erase_paused_flag_reg <= 1'b1;
            end else if (erase_clear_evt) begin
                erase_paused_flag_reg <= 1'b0;
            end
            if (program_suspend_evt) begin
                program_paused_flag_reg <= 1'b1;
            end else if (program_clear_evt) begin
                program_paused_flag_reg <= 1'b0;
            end
        end
    end

    assign status_five_config = {regs_locked_flag, dummy_cycle_count_reg, erase_paused_flag_reg,
        program_paused_flag_reg, abort_cmd_allow_reg, dword_align_select_reg};

    // =====================================================================
    // sixth register and battery test
    bat_state_t bat_state_reg;
    logic [1:0] battery_result_reg;
    logic [LOAD_TIMER_W-1:0] load_timer_reg;
    logic [7:0] battery_test_control;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            battery_cfg <= '0;
        end else if (ce && body_evt && cmd_reg == CMD_WRITE_SR6 && byte_idx_reg == 3'h1 && !regs_locked_flag) begin
            battery_cfg.battery_threshold_sel <= rx_byte_reg[SR6_THRESH_LSB +: 3];
            battery_cfg.battery_load_sel <= rx_byte_reg[SR6_LOAD_LSB +: 2];
            battery_cfg.battery_load_time <= rx_byte_reg[SR6_TIME_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bat_state_reg <= BAT_IDLE;
            battery_result_reg <= BAT_NO_TEST;
            load_timer_reg <= '0;
            battery_load_en <= 1'b0;
        end else if (ce) begin
            case (bat_state_reg)
                BAT_IDLE: begin
                    if (cmd_evt && rx_byte_reg == CMD_BATTERY) begin
                        battery_result_reg <= BAT_TESTING;
                        battery_load_en <= 1'b1;
                        load_timer_reg <= battery_cfg.battery_load_time ?
                            LOAD_TIMER_W'(LONG_LOAD_CYCLES - 1) : LOAD_TIMER_W'(SHORT_LOAD_CYCLES - 1);
                        bat_state_reg <= BAT_LOAD;
                    end
                end
                BAT_LOAD: begin
                    if (load_timer_reg == '0) begin
                        // comparator already set up against the selected threshold
                        battery_result_reg <= bat_sync_reg ? BAT_BELOW : BAT_ABOVE;
                        battery_load_en <= 1'b0;
                        bat_state_reg <= BAT_IDLE;
                    end else begin
                        load_timer_reg <= load_timer_reg - LOAD_TIMER_W'(1);
                    end
                end
                default: bat_state_reg <= BAT_IDLE;
            endcase
        end
    end

    assign battery_test_control = {battery_result_reg, battery_cfg.battery_threshold_sel,
        battery_cfg.battery_load_sel, battery_cfg.battery_load_time};

    // =====================================================================
    // register reads back to the link
    logic read_cmd, is_read5;
    assign is_read5 = cmd_evt ? (rx_byte_reg == CMD_READ_SR5) : (cmd_reg == CMD_READ_SR5);
    assign read_cmd = (cmd_evt & (rx_byte_reg == CMD_READ_SR5 || rx_byte_reg == CMD_READ_SR6)) |
        (body_evt & (cmd_reg == CMD_READ_SR5 || cmd_reg == CMD_READ_SR6));

    // first data byte leaves one byte after the opcode; the crossing needs that slot
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reply_reg <= 8'h00;
            reply_tgl_reg <= 1'b0;
        end else if (ce) begin
            if (frame_start) begin
                reply_tgl_reg <= 1'b0;
            end else if (read_cmd) begin
                reply_reg <= is_read5 ? status_five_config : battery_test_control;
                reply_tgl_reg <= ~reply_tgl_reg;
            end
        end
    end

    // =====================================================================
    // quad read setup and abort
    logic [15:0] addr_hi_reg;
    logic quad_cmd;

    assign quad_cmd = (cmd_reg == CMD_QUAD_READ) || (cmd_reg == CMD_QUAD_READ_ALIGNED);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            addr_hi_reg <= 16'h0000;
            xip_req <= '0;
            xip_req_valid <= 1'b0;
            abort_pulse <= 1'b0;
        end else if (ce) begin
            xip_req_valid <= 1'b0;
            abort_pulse <= cmd_evt & (rx_byte_reg == CMD_TERMINATE) & abort_cmd_allow_reg;
            if (body_evt && quad_cmd && byte_idx_reg < 3'h3) begin
                addr_hi_reg <= {addr_hi_reg[7:0], rx_byte_reg};
            end
            if (body_evt && quad_cmd && byte_idx_reg == 3'h3) begin
                xip_req.addr <= {addr_hi_reg, rx_byte_reg[7:2],
                    (cmd_reg == CMD_QUAD_READ_ALIGNED && dword_align_select_reg) ? 2'h0 : rx_byte_reg[1:0]};
                // mode byte clocks are part of this count
                xip_req.dummy_cycle_count <= dummy_clocks(dummy_cycle_count_reg);
                xip_req.aligned <= (cmd_reg == CMD_QUAD_READ_ALIGNED) && dword_align_select_reg;
                xip_req_valid <= 1'b1;
            end
        end
    end

endmodule : flash_status_config_regs

// >>> src/flash_status_pkg.sv
/*
 * Constants, carrier types and behaviour notes for the flash status and
 * configuration register bank (fifth and sixth status registers).
 * Assumes a 100 MHz system clock and an SPI mode 0 host on its own clock.
 */
// Notes on behaviour
// - The lock flag sets only after the lock opcode followed at once by the two key bytes in the same frame.
// - The dummy field gives 2 clocks for code 000 plus two per step up to 10 for code 100; higher codes are reserved.
// - The programmed dummy count is applied only to the two quad continuous-read commands.
// - The dummy count already covers the two clocks of the mode byte, which the host sends inside it.
// - The erase-paused flag in bit 3 sets whenever an erase is suspended.
// - The program-paused flag in bit 2 sets whenever a program is suspended.
// - Abort commands are ignored while the abort-allow bit is 0 and acted on while it is 1.
// - The abort-allow bit changes only by the fifth-register write command or by a power cycle.
// - With the align bit set the aligned quad read forces the two lowest address bits to zero, no other command.
// - The battery result field in bits 7:6 is updated by running the battery test command.
// - Battery result codes are 00 idle, 01 testing, 10 above threshold and 11 below threshold.
// - The threshold select in bits 5:3 runs from 1.8V at 000 in 0.2V steps to 3.2V at 111.
// - The load select in bits 2:1 picks 10uA, 100uA, 1mA or 10mA.
// - After the load has been applied for its time the result is compared with the threshold and stored.
// - Bit 0 picks a load time of 100us when 0 and 1ms when 1.
// - Every command, address and data byte travels most significant bit first.
package flash_status_pkg;

    // =====================================================================
    // command opcodes and lock key bytes
    localparam logic [7:0] CMD_LOCK = 8'h6F;
    localparam logic [7:0] LOCK_KEY1 = 8'h4D;
    localparam logic [7:0] LOCK_KEY2 = 8'h67;
    localparam logic [7:0] CMD_QUAD_READ = 8'hEB;
    localparam logic [7:0] CMD_QUAD_READ_ALIGNED = 8'hE7;
    localparam logic [7:0] CMD_BATTERY = 8'hEF;
    localparam logic [7:0] CMD_WRITE_SR5 = 8'hC5;
    localparam logic [7:0] CMD_WRITE_SR6 = 8'hC6;
    localparam logic [7:0] CMD_READ_SR5 = 8'h65;
    localparam logic [7:0] CMD_READ_SR6 = 8'h66;
    localparam logic [7:0] CMD_TERMINATE = 8'hF0;

    // =====================================================================
    // fifth register fields
    localparam int SR5_LOCK_BIT = 7;
    localparam int SR5_DUMMY_LSB = 4;
    localparam int SR5_ERASE_BIT = 3;
    localparam int SR5_PROGRAM_BIT = 2;
    localparam int SR5_ABORT_BIT = 1;
    localparam int SR5_ALIGN_BIT = 0;
    localparam logic [2:0] DUMMY_CODE_MAX = 3'h4;
    localparam logic [2:0] DUMMY_RESET = 3'h0;
    localparam logic [3:0] DUMMY_BASE_CLOCKS = 4'h2;

    // =====================================================================
    // sixth register fields
    localparam int SR6_RESULT_LSB = 6;
    localparam int SR6_THRESH_LSB = 3;
    localparam int SR6_LOAD_LSB = 1;
    localparam int SR6_TIME_BIT = 0;
    localparam logic [1:0] BAT_NO_TEST = 2'h0;
    localparam logic [1:0] BAT_TESTING = 2'h1;
    localparam logic [1:0] BAT_ABOVE = 2'h2;
    localparam logic [1:0] BAT_BELOW = 2'h3;

    // =====================================================================
    // timing
    localparam int CLK_MHZ = 100;
    localparam int LOAD_SHORT_US = 100;
    localparam int LOAD_LONG_US = 1000;
    localparam int LOAD_SHORT_CYCLES = LOAD_SHORT_US * CLK_MHZ;
    localparam int LOAD_LONG_CYCLES = LOAD_LONG_US * CLK_MHZ;
    localparam int LOAD_TIMER_W = 17;

    // =====================================================================
    // carriers
    typedef struct packed {
        logic [2:0] battery_threshold_sel;
        logic [1:0] battery_load_sel;
        logic battery_load_time;
    } battery_cfg_t;

    typedef struct packed {
        logic [23:0] addr;
        logic [3:0] dummy_cycle_count;
        logic aligned;
    } xip_req_t;

endpackage : flash_status_pkg

// >>> testbench/flash_status_monitor.sv
/*
 * Port checker for the status register bank, bound to the top module.
 * Assumes a single clk domain and that the bench keeps ce high.
 */
`timescale 1ns/1ps
module flash_status_monitor
    import flash_status_pkg::*;
#(
    parameter int SHORT_LOAD_CYCLES = LOAD_SHORT_CYCLES,
    parameter int LONG_LOAD_CYCLES = LOAD_LONG_CYCLES
) (
    // system
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    // spi link
    input wire logic spi_cs_n,
    input wire logic spi_miso,
    input wire logic spi_miso_oe,
    // outputs under watch
    input wire logic battery_load_en,
    input wire battery_cfg_t battery_cfg,
    input wire xip_req_t xip_req,
    input wire logic xip_req_valid,
    input wire logic abort_pulse,
    input wire logic regs_locked_flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // ==================================================================
    // load time counter
    int load_cnt;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            load_cnt <= 0;
        end else if (ce) begin
            load_cnt <= battery_load_en ? load_cnt + 1 : 0;
        end
    end

    // ==================================================================
    // properties
    property p_lock_sticky;
        regs_locked_flag |=> regs_locked_flag;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("lock flag dropped");
    property p_lock_in_frame;
        $rose(regs_locked_flag) |-> !$past(spi_cs_n, 4);
    endproperty
    a_lock_in_frame: assert property (p_lock_in_frame) else $error("lock flag set outside a frame");
    property p_dummy_range;
        xip_req_valid |-> xip_req.dummy_cycle_count inside {4'h2, 4'h4, 4'h6, 4'h8, 4'hA};
    endproperty
    a_dummy_range: assert property (p_dummy_range) else $error("dummy count off the table");
    property p_xip_hold;
        !xip_req_valid |-> $stable(xip_req);
    endproperty
    a_xip_hold: assert property (p_xip_hold) else $error("read request moved without valid");
    property p_xip_pulse;
        xip_req_valid |=> !xip_req_valid;
    endproperty
    a_xip_pulse: assert property (p_xip_pulse) else $error("read request valid too long");
    property p_abort_pulse;
        abort_pulse |=> !abort_pulse;
    endproperty
    a_abort_pulse: assert property (p_abort_pulse) else $error("abort pulse too long");
    property p_load_time;
        $fell(battery_load_en) |->
            load_cnt == (battery_cfg.battery_load_time ? LONG_LOAD_CYCLES : SHORT_LOAD_CYCLES);
    endproperty
    a_load_time: assert property (p_load_time) else $error("load applied for wrong time");
    property p_cfg_hold;
        battery_load_en && $past(battery_load_en) |-> $stable(battery_cfg);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("battery setup moved during test");
    property p_idle_line;
        spi_cs_n && $past(spi_cs_n) |-> !spi_miso_oe && !spi_miso;
    endproperty
    a_idle_line: assert property (p_idle_line) else $error("data line driven while deselected");

    c_dummy_max: cover property (xip_req_valid && xip_req.dummy_cycle_count == 4'hA);
    c_long_load: cover property ($fell(battery_load_en) && battery_cfg.battery_load_time);
    c_lock: cover property ($rose(regs_locked_flag));
    c_abort: cover property (abort_pulse);
endmodule : flash_status_monitor

bind flash_status_config_regs flash_status_monitor #(
    .SHORT_LOAD_CYCLES(SHORT_LOAD_CYCLES), .LONG_LOAD_CYCLES(LONG_LOAD_CYCLES)
) i_monitor (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .spi_cs_n(spi_cs_n), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .battery_load_en(battery_load_en), .battery_cfg(battery_cfg),
    .xip_req(xip_req), .xip_req_valid(xip_req_valid), .abort_pulse(abort_pulse),
    .regs_locked_flag(regs_locked_flag)
);

// >>> testbench/spi_host_model.sv
/*
 * Behavioural spi host, mode 0, 125 ns link clock that runs only in frames.
 * Assumes the device drives its data line from falling edges.
 */
`timescale 1ns/1ps
module spi_host_model (
    // link toward the device
    output logic spi_clk,
    output logic spi_cs_n,
    output logic spi_mosi,
    input wire logic spi_miso
);
    initial {spi_clk, spi_cs_n, spi_mosi} = 3'b011;

    // one whole frame; released data line shows the inverse of its last bit
    task automatic xfer(input logic [7:0] tx[$], output logic [7:0] rx[$]);
        logic [7:0] b;
        rx = {};
        #3.7 spi_cs_n = 1'b0;
        #40;
        foreach (tx[k]) begin
            for (int i = 7; i >= 0; i--) begin
                spi_mosi = tx[k][i];
                #62.5 spi_clk = 1'b1;
                b[i] = spi_miso;
                #62.5 spi_clk = 1'b0;
            end
            rx.push_back(b);
        end
        #62.5 spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;
        #100;
    endtask : xfer
endmodule : spi_host_model

// >>> testbench/tb.sv
/*
 * Self-checking bench: spi host model plus a reference model of both registers.
 * Assumes shortened load counts and the opcodes of the package.
 */
`timescale 1ns/1ps
module tb;
    import flash_status_pkg::*;
    localparam int SHORT_N = 20;
    localparam int LONG_N = 400;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] evt = 4'h0;
    logic below = 1'b0;
    wire spi_clk, spi_cs_n, spi_mosi;
    logic spi_miso, miso_oe, load_en, xip_valid, abort_p, locked;
    battery_cfg_t cfg;
    xip_req_t xip;
    logic [7:0] rxq[$];
    int fail_count = 0, tests_run = 0, cycles = 0, aborts = 0, valids = 0, a;
    // ==================================================================
    // reference model
    logic [2:0] dmy;
    logic es, ps, ab, al, lk;
    logic [5:0] b6;

    flash_status_config_regs #(.SHORT_LOAD_CYCLES(SHORT_N), .LONG_LOAD_CYCLES(LONG_N)) i_dut (
        .clk(clk), .sys_rst(sys_rst), .ce(1'b1), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(miso_oe), .erase_suspend_evt(evt[0]),
        .erase_clear_evt(evt[1]), .program_suspend_evt(evt[2]), .program_clear_evt(evt[3]),
        .battery_below_async(below), .battery_load_en(load_en), .battery_cfg(cfg), .xip_req(xip),
        .xip_req_valid(xip_valid), .abort_pulse(abort_p), .regs_locked_flag(locked));
    spi_host_model i_host (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso));

    always #5 clk = ~clk;
    // ceiling far above the ~19k cycles of the run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (abort_p === 1'b1) aborts <= aborts + 1;
        if (xip_valid === 1'b1) valids <= valids + 1;
        if (cycles == 60000) begin
            fail_count++;
            test_done();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    function automatic logic [7:0] sr5();
        return {lk, dmy, es, ps, ab, al};
    endfunction : sr5
    task automatic rd(input logic [7:0] op, input logic [7:0] exp);
        i_host.xfer({op, 8'h00, 8'h00}, rxq);
        check("register", rxq[2], exp);
    endtask : rd
    task automatic wr(input logic [7:0] op, input logic [7:0] v);
        i_host.xfer({op, v}, rxq);
        if (!lk && op == CMD_WRITE_SR5) begin
            if (v[6:4] <= DUMMY_CODE_MAX) dmy = v[6:4];
            ab = v[1];
            al = v[0];
        end
        if (!lk && op == CMD_WRITE_SR6) b6 = v[5:0];
    endtask : wr
    task automatic xread(input logic [7:0] op, input logic [23:0] adr, input logic go);
        int v0;
        v0 = valids;
        i_host.xfer({op, adr[23:16], adr[15:8], adr[7:0]}, rxq);
        check("request count", valids, v0 + int'(go));
        if (go) begin
            check("dummy", xip.dummy_cycle_count, 2 + 2 * dmy);
            check("address", xip.addr, (op == CMD_QUAD_READ_ALIGNED && al) ? {adr[23:2], 2'b00} : adr);
        end
    endtask : xread
    task automatic pulse(input int k);
        @(posedge clk) #1 evt[k] = 1'b1;
        @(posedge clk) #1 evt[k] = 1'b0;
        repeat (4) @(posedge clk);
    endtask : pulse
    task automatic do_reset();
        @(posedge clk) #1 sys_rst = 1'b1;
        repeat (5) @(posedge clk);
        #1 sys_rst = 1'b0;
        {dmy, es, ps, ab, al, lk, b6} = '0;
        repeat (3) @(posedge clk);
    endtask : do_reset
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    // ==================================================================
    // tests
    initial begin
        void'($urandom(6));
        do_reset();
        rd(CMD_READ_SR5, 8'h00);
        rd(CMD_READ_SR6, 8'h00);
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            wr(CMD_WRITE_SR5, {1'b0, 3'(c), 4'h0});
            rd(CMD_READ_SR5, sr5());
            xread(CMD_QUAD_READ, 24'($urandom), 1'b1);
        end
        xread(8'h03, 24'($urandom), 1'b0);
        wr(CMD_WRITE_SR5, 8'h41);
        xread(CMD_QUAD_READ_ALIGNED, 24'($urandom), 1'b1);
        xread(CMD_QUAD_READ, 24'($urandom), 1'b1);
        wr(CMD_WRITE_SR5, 8'h00);
        xread(CMD_QUAD_READ_ALIGNED, 24'h00000F, 1'b1);
        $display("test dummy and align done");
        a = aborts;
        i_host.xfer({CMD_TERMINATE}, rxq);
        check("aborts", aborts, a);
        wr(CMD_WRITE_SR5, 8'h02);
        i_host.xfer({CMD_TERMINATE}, rxq);
        check("aborts", aborts, a + 1);
        do_reset();
        rd(CMD_READ_SR5, sr5());
        $display("test abort done");
        pulse(0);
        es = 1'b1;
        rd(CMD_READ_SR5, sr5());
        pulse(2);
        ps = 1'b1;
        rd(CMD_READ_SR5, sr5());
        pulse(1);
        es = 1'b0;
        rd(CMD_READ_SR5, sr5());
        pulse(3);
        ps = 1'b0;
        rd(CMD_READ_SR5, sr5());
        $display("test suspend done");
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) #1 below = i[1];
            wr(CMD_WRITE_SR6, {2'b00, 5'($urandom), i[0]});
            i_host.xfer({CMD_BATTERY}, rxq);
            check("config", cfg, b6);
            if (b6[0]) begin
                check("load", load_en, 1'b1);
                rd(CMD_READ_SR6, {BAT_TESTING, b6});
            end
            repeat (LONG_N) @(posedge clk);
            check("load", load_en, 1'b0);
            rd(CMD_READ_SR6, {below ? BAT_BELOW : BAT_ABOVE, b6});
        end
        $display("test battery done");
        i_host.xfer({CMD_LOCK, LOCK_KEY1}, rxq);
        i_host.xfer({CMD_LOCK, LOCK_KEY2, LOCK_KEY1}, rxq);
        check("lock", locked, 1'b0);
        i_host.xfer({CMD_LOCK, LOCK_KEY1, LOCK_KEY2}, rxq);
        lk = 1'b1;
        check("lock", locked, 1'b1);
        wr(CMD_WRITE_SR5, 8'h3F);
        rd(CMD_READ_SR5, sr5());
        $display("test lock done");
        test_done();
    end
endmodule : tb
